// *** lpt_pkg.sv ***
// Package for the low-power timer pair: APB register map, field layout,
// reset values, clock-select codes and filter settings.
// Assumes a 32-bit APB with word-aligned registers.
package lpt_pkg;
  // Register byte offsets, instance A in the low page, instance B at +0x40
  localparam logic [7:0] LPT_OFF_ISR   = 8'h00;  // Sticky event flags
  localparam logic [7:0] LPT_OFF_IER   = 8'h04;  // Interrupt mask
  localparam logic [7:0] LPT_OFF_CFG   = 8'h08;  // Configuration
  localparam logic [7:0] LPT_OFF_CR    = 8'h0C;  // Control and start
  localparam logic [7:0] LPT_OFF_CMP   = 8'h10;  // Compare value
  localparam logic [7:0] LPT_OFF_ARR   = 8'h14;  // Autoreload value
  localparam logic [7:0] LPT_OFF_CNT   = 8'h18;  // Counter, read only
  localparam logic [7:0] LPT_OFF_STAT  = 8'h1C;  // Live state, read only
  localparam logic [7:0] LPT_INST_STEP = 8'h40;  // Byte distance between instances
  // Flag bit positions in the status and mask registers
  localparam int LPT_F_ARRM = 0;  // Autoreload match
  localparam int LPT_F_CMPM = 1;  // Compare match
  localparam int LPT_F_TRIG = 2;  // Hardware trigger seen
  localparam int LPT_F_WAKE = 3;  // Wakeup request raised
  localparam int LPT_NFLAGS = 4;
  // Configuration field positions
  localparam int LPT_C_CKSEL  = 0;  // 3 bits, counting clock source
  localparam int LPT_C_WAVE   = 3;  // 1 = PWM, 0 = single pulse
  localparam int LPT_C_POL    = 4;  // Output polarity
  localparam int LPT_C_TRIGEN = 5;  // 1 = hardware trigger starts
  localparam int LPT_C_TRIGSEL= 6;  // 2 bits, trigger input select
  localparam int LPT_C_FILT   = 8;  // 2 bits, glitch filter depth code
  localparam int LPT_C_ENC    = 10; // Encoder mode, instance A only
  localparam int LPT_C_WAKEEN = 11; // Wakeup enable
  localparam int LPT_CFG_W    = 12;
  // Control bits
  localparam int LPT_R_EN     = 0;  // Timer enable
  localparam int LPT_R_SSTART = 1;  // One-shot software start, self clearing
  localparam int LPT_R_CSTART = 2;  // Continuous software start, self clearing
  // Reset values
  localparam logic [15:0] LPT_ARR_RST = 16'hFFFF;
  localparam logic [15:0] LPT_CMP_RST = 16'h0000;
  // Counting clock sources
  typedef enum logic [2:0] {
    LPT_CK_PCLK   = 3'b000,  // Peripheral bus clock
    LPT_CK_SLOWX  = 3'b001,  // slow_external_osc
    LPT_CK_SLOWIA = 3'b010,  // slow_internal_osc_a
    LPT_CK_SLOWIB = 3'b011,  // slow_internal_osc_b
    LPT_CK_FASTI  = 3'b100,  // fast_internal_osc
    LPT_CK_PIN    = 3'b101   // External input pin
  } lpt_cksel_t;
  // Run state of one counter
  typedef enum logic [1:0] {
    LPT_ST_IDLE = 2'b00,  // Waiting for start
    LPT_ST_ARM  = 2'b01,  // Waiting for hardware trigger
    LPT_ST_RUN  = 2'b10   // Counting
  } lpt_state_t;
  // Glitch filter depths per code, in samples
  localparam logic [2:0] LPT_FILT_1 = 3'h1;
  localparam logic [2:0] LPT_FILT_2 = 3'h2;
  localparam logic [2:0] LPT_FILT_4 = 3'h4;
  localparam logic [2:0] LPT_FILT_7 = 3'h7;
endpackage

// *** lpt_core.sv ***
// One low-power timer instance: glitch filters, clock selection, counter,
// output waveform, one-shot control, encoder mode and flags.
// Assumes oscillator ticks and pins arrive synchronous to pclk.
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module lpt_core #(
  parameter bit HAS_ENC = 1'b1  // Encoder mode present
) (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 clk_en,
  // Configuration
  input  wire logic [lpt_pkg::LPT_CFG_W-1:0] cfg,
  input  wire logic                 enable,
  input  wire logic                 sw_single,
  input  wire logic                 sw_cont,
  input  wire logic [15:0]          cmp_val,
  input  wire logic [15:0]          arr_val,
  // Clock ticks and pins
  input  wire logic [3:0]           osc_tick,
  input  wire logic                 ext_in,
  input  wire logic                 ext_in2,
  input  wire logic [3:0]           trig_in,
  // Results
  output logic [15:0]               count,
  output logic                      wave_out,
  output logic [lpt_pkg::LPT_NFLAGS-1:0] evt,
  output logic [1:0]                run_state
);
  lpt_pkg::lpt_state_t state;       // Run state
  logic                oneshot;     // Current run is one-shot
  logic [2:0]          f_cnt0;      // Filter counter, input 1
  logic [2:0]          f_cnt1;      // Filter counter, input 2
  logic                f_in0;       // Filtered input 1
  logic                f_in1;       // Filtered input 2
  logic                f_in0_d;     // Previous filtered input 1
  logic                trig_f;      // Filtered trigger level
  logic [2:0]          f_cntt;      // Filter counter, trigger
  logic                trig_d;      // Previous trigger
  logic                tick;        // Counting tick this cycle
  logic [2:0]          depth;       // Filter depth
  logic                trig_edge;   // Rising trigger edge
  logic                enc;         // Encoder mode active

  // Depth decode, shared by all three filters
  function automatic logic [2:0] f_depth(input logic [1:0] code);
    unique case (code)
      2'd0: f_depth = lpt_pkg::LPT_FILT_1;
      2'd1: f_depth = lpt_pkg::LPT_FILT_2;
      2'd2: f_depth = lpt_pkg::LPT_FILT_4;
      default: f_depth = lpt_pkg::LPT_FILT_7;
    endcase
  endfunction
  assign depth = f_depth(cfg[lpt_pkg::LPT_C_FILT +: 2]);
  assign enc   = HAS_ENC & cfg[lpt_pkg::LPT_C_ENC];  // R09

  ////////////////////////////////////////////////////////////////////////
  // Glitch filters: a level passes only after it holds for depth samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f_cnt0 <= 3'h0; f_cnt1 <= 3'h0; f_cntt <= 3'h0;
      f_in0 <= 1'b0; f_in1 <= 1'b0; trig_f <= 1'b0;
    end else if (clk_en) begin
      // R08: every external input filtered before use
      if (ext_in == f_in0) f_cnt0 <= 3'h0;
      else if (f_cnt0 + 3'h1 >= depth) begin f_in0 <= ext_in; f_cnt0 <= 3'h0; end
      else f_cnt0 <= f_cnt0 + 3'h1;
      if (ext_in2 == f_in1) f_cnt1 <= 3'h0;
      else if (f_cnt1 + 3'h1 >= depth) begin f_in1 <= ext_in2; f_cnt1 <= 3'h0; end
      else f_cnt1 <= f_cnt1 + 3'h1;
      if (trig_in[cfg[lpt_pkg::LPT_C_TRIGSEL +: 2]] == trig_f) f_cntt <= 3'h0;
      else if (f_cntt + 3'h1 >= depth) begin
        trig_f <= ~trig_f; f_cntt <= 3'h0;
      end else f_cntt <= f_cntt + 3'h1;
    end
  end

  // Edge memories for filtered signals
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f_in0_d <= 1'b0; trig_d <= 1'b0;
    end else if (clk_en) begin
      f_in0_d <= f_in0; trig_d <= trig_f;
    end
  end
  assign trig_edge = trig_f & ~trig_d;

  // Tick selection; the pin path needs no oscillator at all
  always_comb begin
    unique case (cfg[lpt_pkg::LPT_C_CKSEL +: 3])  // R06
      lpt_pkg::LPT_CK_PCLK:   tick = 1'b1;
      lpt_pkg::LPT_CK_SLOWX:  tick = osc_tick[0];
      lpt_pkg::LPT_CK_SLOWIA: tick = osc_tick[1];
      lpt_pkg::LPT_CK_SLOWIB: tick = osc_tick[2];
      lpt_pkg::LPT_CK_FASTI:  tick = osc_tick[3];
      lpt_pkg::LPT_CK_PIN:    tick = f_in0 & ~f_in0_d;  // R07
      default:                tick = 1'b0;
    endcase
    if (enc) tick = f_in0 ^ f_in0_d;  // Encoder counts on input 1 edges
  end

  ////////////////////////////////////////////////////////////////////////
  // Run control: idle, armed for trigger, counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= lpt_pkg::LPT_ST_IDLE; oneshot <= 1'b0;
    end else if (clk_en) begin
      if (!enable) state <= lpt_pkg::LPT_ST_IDLE;
      else begin
        unique case (state)
          lpt_pkg::LPT_ST_IDLE, lpt_pkg::LPT_ST_ARM: begin
            if (sw_single | sw_cont) begin  // R05
              oneshot <= sw_single;  // R04
              state <= cfg[lpt_pkg::LPT_C_TRIGEN] ? lpt_pkg::LPT_ST_ARM : lpt_pkg::LPT_ST_RUN;
            end else if (state == lpt_pkg::LPT_ST_ARM && trig_edge) state <= lpt_pkg::LPT_ST_RUN;  // R05
          end
          lpt_pkg::LPT_ST_RUN: begin
            if (tick && !enc && count == arr_val && oneshot)  // R16
              state <= cfg[lpt_pkg::LPT_C_TRIGEN] ? lpt_pkg::LPT_ST_ARM : lpt_pkg::LPT_ST_IDLE;
          end
          default: state <= lpt_pkg::LPT_ST_IDLE;
        endcase
      end
    end
  end
  assign run_state = state;

  // Counter: up with wrap at autoreload, or quadrature up/down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) count <= 16'h0000;
    else if (clk_en) begin
      if (!enable) count <= 16'h0000;
      else if (state == lpt_pkg::LPT_ST_RUN && tick) begin
        if (enc) begin  // R09
          if (f_in0 ^ f_in1) count <= (count == arr_val) ? 16'h0000 : count + 16'h0001;
          else count <= (count == 16'h0000) ? arr_val : count - 16'h0001;
        end else if (count == arr_val) count <= 16'h0000;  // R14
        else count <= count + 16'h0001;  // R02
      end
    end
  end

  // Output: asserted above compare, dropped at autoreload; pulse mode holds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wave_out <= 1'b0;
    else if (clk_en) begin
      if (state != lpt_pkg::LPT_ST_RUN) wave_out <= cfg[lpt_pkg::LPT_C_POL];
      else if (tick && count == arr_val)  // R15
        wave_out <= cfg[lpt_pkg::LPT_C_WAVE] ? cfg[lpt_pkg::LPT_C_POL] : wave_out;
      else if (tick && count == cmp_val) wave_out <= ~cfg[lpt_pkg::LPT_C_POL];  // R03
    end
  end

  // Event pulses, one cycle each
  always_comb begin
    evt = '0;
    evt[lpt_pkg::LPT_F_ARRM] = state == lpt_pkg::LPT_ST_RUN && tick && count == arr_val;  // R14
    evt[lpt_pkg::LPT_F_CMPM] = state == lpt_pkg::LPT_ST_RUN && tick && count == cmp_val;  // R15
    evt[lpt_pkg::LPT_F_TRIG] = state == lpt_pkg::LPT_ST_ARM && trig_edge;
    evt[lpt_pkg::LPT_F_WAKE] = cfg[lpt_pkg::LPT_C_WAKEEN] &&
                               (evt[lpt_pkg::LPT_F_ARRM] | evt[lpt_pkg::LPT_F_CMPM]);  // R11
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter wraps to zero in the cycle after the autoreload match tick
  arr_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && state == lpt_pkg::LPT_ST_RUN && tick && !enc && count == arr_val && enable
    |=> count == 16'h0000) else $error("counter did not wrap");  // R14
  count_up_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && enable && state == lpt_pkg::LPT_ST_RUN && tick && !enc && count != arr_val
    |=> count == $past(count) + 16'h0001) else $error("counter did not step");  // R02
  oneshot_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && enable && oneshot && evt[lpt_pkg::LPT_F_ARRM] && !enc && !sw_single && !sw_cont
    |=> state != lpt_pkg::LPT_ST_RUN) else $error("one-shot kept running");  // R16
  pwm_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && cfg[lpt_pkg::LPT_C_WAVE] && evt[lpt_pkg::LPT_F_ARRM] && enable
    |=> wave_out == $past(cfg[lpt_pkg::LPT_C_POL])) else $error("pwm not restored");  // R15
  idle_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !enable |=> count == 16'h0000 && state == lpt_pkg::LPT_ST_IDLE)
    else $error("disabled timer moved");  // R04
  enc_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !HAS_ENC |-> !enc) else $error("encoder present on instance");  // R09
  wake_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg[lpt_pkg::LPT_C_WAKEEN] && evt[lpt_pkg::LPT_F_ARRM] |-> evt[lpt_pkg::LPT_F_WAKE])
    else $error("wakeup missing");  // R11
  hw_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && enable && state == lpt_pkg::LPT_ST_ARM && trig_edge && !sw_single && !sw_cont
    |=> state == lpt_pkg::LPT_ST_RUN) else $error("trigger did not start");  // R05
endmodule
`default_nettype wire

// *** lpt_top.sv ***
// Low-power timer pair with APB register access, flags and interrupt.
// Assumes oscillator ticks are one-cycle enables in the pclk domain and that
// the pclk domain is the always-on domain in every stop state.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// R01: two independent timer instances
// R02: 16-bit up counter to autoreload
// R03: pulse or PWM output from compare
// R04: continuous or one-shot counting
// R05: software or hardware trigger start
// R06: selectable internal counting clock source
// R07: external pin clocking without oscillators
// R08: programmable glitch filter on inputs
// R09: encoder mode on first instance only
// R10: keeps running in stop on slow clocks
// R11: wakeup request from each instance
// R12: first instance runs in all stops
// R13: second instance needs only shallower stops
// R14: wrap to zero, autoreload flag
// R15: PWM toggles at compare, restores at reload
// R16: one-shot stops, awaits new trigger
module lpt_top (
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Oscillator ticks: slow ext, slow int a, slow int b, fast int
  input  wire logic [3:0]  osc_tick,
  // Timer pins, index 0 = lowpower_timer_a, 1 = lowpower_timer_b
  input  wire logic [1:0]  lpt_in1,
  input  wire logic [1:0]  lpt_in2,
  input  wire logic [3:0]  lpt_trig,
  output logic [1:0]       lpt_out,
  // System
  output logic [1:0]       wakeup_req,
  output logic             irq
);
  localparam int NI = 2;  // Instances

  logic [lpt_pkg::LPT_NFLAGS-1:0] isr [NI];   // Sticky flags
  logic [lpt_pkg::LPT_NFLAGS-1:0] ier [NI];   // Mask
  logic [lpt_pkg::LPT_CFG_W-1:0]  cfg [NI];   // Configuration
  logic [NI-1:0]                  en;         // Enable bits
  logic [NI-1:0]                  s_single;   // Software one-shot start pulse
  logic [NI-1:0]                  s_cont;     // Software continuous start pulse
  logic [15:0]                    cmp [NI];   // Compare
  logic [15:0]                    arr [NI];   // Autoreload
  logic [15:0]                    cnt [NI];   // Live count
  logic [1:0]                     st  [NI];   // Live state
  logic [lpt_pkg::LPT_NFLAGS-1:0] evt [NI];   // Event pulses
  logic                           wr;         // Write access phase
  logic                           inst;       // Addressed instance
  logic [7:0]                     loc;        // Offset within instance
  logic                           hit;        // Mapped address

  assign pready  = 1'b1;  // Zero wait states
  assign wr      = psel & penable & pwrite;
  assign inst    = paddr >= lpt_pkg::LPT_INST_STEP;
  assign loc     = inst ? paddr - lpt_pkg::LPT_INST_STEP : paddr;
  assign hit     = paddr < 2 * lpt_pkg::LPT_INST_STEP && loc <= lpt_pkg::LPT_OFF_STAT && loc[1:0] == 2'b00;
  assign pslverr = psel & penable & ~hit;

  ////////////////////////////////////////////////////////////////////////
  // Instances; the counters live on the pclk tick path, so slow or
  // pin clocking keeps counting whenever the always-on pclk runs
  for (genvar i = 0; i < NI; i++) begin : g_inst  // R01
    lpt_core #(
      .HAS_ENC (i == 0)  // R09
    ) u_core (
      .pclk      (pclk),
      .presetn   (presetn),
      .clk_en    (clk_en),
      .cfg       (cfg[i]),
      .enable    (en[i]),
      .sw_single (s_single[i]),
      .sw_cont   (s_cont[i]),
      .cmp_val   (cmp[i]),
      .arr_val   (arr[i]),
      .osc_tick  (osc_tick),  // R10
      .ext_in    (lpt_in1[i]),
      .ext_in2   (lpt_in2[i]),
      .trig_in   (lpt_trig),
      .count     (cnt[i]),
      .wave_out  (lpt_out[i]),
      .evt       (evt[i]),
      .run_state (st[i])
    );
    // Wakeup level while an enabled wake flag stands; R12 and R13 are met
    // by the power domain placing each instance, not by logic here
    assign wakeup_req[i] = isr[i][lpt_pkg::LPT_F_WAKE];  // R11

    // Register writes for this instance
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ier[i] <= '0; cfg[i] <= '0; en[i] <= 1'b0;
        s_single[i] <= 1'b0; s_cont[i] <= 1'b0;
        cmp[i] <= lpt_pkg::LPT_CMP_RST; arr[i] <= lpt_pkg::LPT_ARR_RST;
      end else if (clk_en) begin
        s_single[i] <= 1'b0;
        s_cont[i]   <= 1'b0;
        if (wr && hit && inst == 1'(i)) begin
          unique case (loc)
            lpt_pkg::LPT_OFF_IER: ier[i] <= pwdata[lpt_pkg::LPT_NFLAGS-1:0];
            lpt_pkg::LPT_OFF_CFG: cfg[i] <= pwdata[lpt_pkg::LPT_CFG_W-1:0];
            lpt_pkg::LPT_OFF_CR: begin
              en[i]       <= pwdata[lpt_pkg::LPT_R_EN];
              s_single[i] <= pwdata[lpt_pkg::LPT_R_SSTART];  // R05
              s_cont[i]   <= pwdata[lpt_pkg::LPT_R_CSTART];  // R04
            end
            lpt_pkg::LPT_OFF_CMP: cmp[i] <= pwdata[15:0];  // R03
            lpt_pkg::LPT_OFF_ARR: arr[i] <= pwdata[15:0];  // R02
            default: ;
          endcase
        end
      end
    end

    // Sticky flags: a new event wins over a write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) isr[i] <= '0;
      else if (clk_en) begin
        if (wr && hit && inst == 1'(i) && loc == lpt_pkg::LPT_OFF_ISR)
          isr[i] <= (isr[i] & ~pwdata[lpt_pkg::LPT_NFLAGS-1:0]) | evt[i];
        else
          isr[i] <= isr[i] | evt[i];
      end
    end

    flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && evt[i][lpt_pkg::LPT_F_ARRM] |=> isr[i][lpt_pkg::LPT_F_ARRM])
      else $error("reload flag not set");  // R14
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, registered at the setup cycle so it stands in access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (clk_en && psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      if (hit) begin
        unique case (loc)
          lpt_pkg::LPT_OFF_ISR:  prdata <= 32'(isr[inst]);
          lpt_pkg::LPT_OFF_IER:  prdata <= 32'(ier[inst]);
          lpt_pkg::LPT_OFF_CFG:  prdata <= 32'(cfg[inst]);
          lpt_pkg::LPT_OFF_CR:   prdata <= 32'(en[inst]);
          lpt_pkg::LPT_OFF_CMP:  prdata <= 32'(cmp[inst]);
          lpt_pkg::LPT_OFF_ARR:  prdata <= 32'(arr[inst]);
          lpt_pkg::LPT_OFF_CNT:  prdata <= 32'(cnt[inst]);
          lpt_pkg::LPT_OFF_STAT: prdata <= 32'(st[inst]);
          default:               prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // One level interrupt for both instances
  assign irq = |(isr[0] & ier[0]) | |(isr[1] & ier[1]);

  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    (isr[1][lpt_pkg::LPT_F_CMPM] && ier[1][lpt_pkg::LPT_F_CMPM]) |-> irq)
    else $error("interrupt not raised");  // R11
endmodule
`default_nettype wire

// *** lpt_far.sv ***
// Far-side model: oscillator ticks, timer pins and trigger lines.
// Assumes the bench steers it through tick_on, pin_go, trig_go and trig_sel.
`timescale 1ns/10ps
`default_nettype none
module lpt_far (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Steering from the bench
  input  wire logic       tick_on,
  input  wire logic       pin_go,
  input  wire logic       trig_go,
  input  wire logic [1:0] trig_sel,
  // Lines into the timer pair
  output logic [3:0]      osc_tick,
  output logic [1:0]      lpt_in1,
  output logic [1:0]      lpt_in2,
  output logic [3:0]      lpt_trig
);
  logic [2:0] div;  // Free-running tick divider
  logic [2:0] ph;   // Pin phase, restarts while pins rest
  logic [3:0] lag;  // Makes in2 trail in1 by a quarter period
  logic       in1;  // Pin level shared by both instances
  ////////////////////////////////////////////////////////////////////////////
  // Slow sources tick once in 8 cycles, the fast one every other cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div <= 3'h0;
    else div <= div + 3'h1;
  end
  // Ticks stop when the oscillators are off, as in deep sleep
  assign osc_tick = tick_on ? {div[0], div == 3'h2, div == 3'h1, div == 3'h0} : 4'h0;
  // Pin toggles every 8 cycles; a held level is legal for a pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph  <= 3'h0;
      in1 <= 1'b0;
      lag <= 4'h0;
    end else begin
      ph <= pin_go ? ph + 3'h1 : 3'h0;
      if (pin_go && ph == 3'h7) in1 <= ~in1;
      lag <= {lag[2:0], in1};
    end
  end
  assign lpt_in1  = {in1, in1};
  assign lpt_in2  = {lag[3], lag[3]};
  assign lpt_trig = trig_go ? 4'h1 << trig_sel : 4'h0;
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the timer pair over APB.
// Assumes lpt_far stands on the pin side; clk_en is held high.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  osc_tick, lpt_trig;
  logic [1:0]  lpt_in1, lpt_in2, lpt_out, wakeup_req, trig_sel, ts, fs;
  logic        tick_on, pin_go, trig_go, last_err;
  logic [31:0] exp_q[$];  // Expected read data, oldest first
  int          err_count, n_tests;
  localparam logic [7:0] B = lpt_pkg::LPT_INST_STEP;
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  lpt_top i_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_tick(osc_tick), .lpt_in1(lpt_in1), .lpt_in2(lpt_in2),
    .lpt_trig(lpt_trig), .lpt_out(lpt_out), .wakeup_req(wakeup_req), .irq(irq));
  lpt_far i_far (.pclk(pclk), .presetn(presetn), .tick_on(tick_on), .pin_go(pin_go),
    .trig_go(trig_go), .trig_sel(trig_sel), .osc_tick(osc_tick), .lpt_in1(lpt_in1),
    .lpt_in2(lpt_in2), .lpt_trig(lpt_trig));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // One APB transfer; an idle edge after it keeps drivers single-assigned
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    last_err = pslverr;
    if (k >= 50) begin
      err_count++;
      wrap_up;
    end
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  // Bounded wait for the interrupt line
  task automatic wait_irq;
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 200) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 200) begin
      err_count++;
      wrap_up;
    end
  endtask
  task automatic do_reset;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  // Read data is taken at the completing access edge
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) check("prdata", prdata, exp_q.pop_front());
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, tick_on, pin_go, trig_go} = '0;
    paddr = 8'h00; pwdata = 32'h0000_0000; trig_sel = 2'h0;
    err_count = 0; n_tests = 0;
    void'($urandom(43));
    do_reset;
    // Reset values and an unmapped place
    rd(lpt_pkg::LPT_OFF_ARR, 32'h0000_FFFF);
    rd(lpt_pkg::LPT_OFF_CMP, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    check("pslverr", 32'(last_err), 32'h0000_0001);
    // One-shot PWM on A from pclk, wake enabled, reload flag unmasked
    wr(lpt_pkg::LPT_OFF_ARR, 32'h0000_0005);
    wr(lpt_pkg::LPT_OFF_CMP, 32'h0000_0002);
    wr(lpt_pkg::LPT_OFF_CFG, 32'h0000_0808);
    wr(lpt_pkg::LPT_OFF_IER, 32'h0000_0001);
    wr(lpt_pkg::LPT_OFF_CR, 32'h0000_0003);
    wait_irq;
    rd(lpt_pkg::LPT_OFF_STAT, 32'h0000_0000);
    rd(lpt_pkg::LPT_OFF_CNT, 32'h0000_0000);
    rd(lpt_pkg::LPT_OFF_ISR, 32'h0000_000B);
    check("lpt_out", 32'(lpt_out[0]), 32'h0000_0000);
    check("wakeup_req", 32'(wakeup_req[0]), 32'h0000_0001);
    wr(lpt_pkg::LPT_OFF_ISR, 32'h0000_000F);
    check("irq", 32'(irq), 32'h0000_0000);
    // Hardware-triggered one-shot pulse, random line and filter depth
    ts = 2'($urandom);
    fs = 2'($urandom);
    trig_sel <= ts;
    wr(lpt_pkg::LPT_OFF_CFG, 32'h0000_0020 | (32'(fs) << 8) | (32'(ts) << 6));
    wr(lpt_pkg::LPT_OFF_CR, 32'h0000_0003);
    rd(lpt_pkg::LPT_OFF_STAT, 32'h0000_0001);
    trig_go <= 1'b1;
    repeat (10) @(posedge pclk);
    trig_go <= 1'b0;
    wait_irq;
    rd(lpt_pkg::LPT_OFF_STAT, 32'h0000_0001);
    rd(lpt_pkg::LPT_OFF_ISR, 32'h0000_0007);
    // Pulse held through reload, then back to the idle level once armed again
    check("lpt_out", 32'(lpt_out[0]), 32'h0000_0000);
    wr(lpt_pkg::LPT_OFF_ISR, 32'h0000_000F);
    // B runs continuously from a random oscillator tick while A stays armed
    tick_on <= 1'b1;
    fs = 2'($urandom);
    wr(B + lpt_pkg::LPT_OFF_ARR, 32'h0000_0003);
    wr(B + lpt_pkg::LPT_OFF_CFG, 32'h0000_0001 + 32'(fs));
    wr(B + lpt_pkg::LPT_OFF_CR, 32'h0000_0005);
    repeat (40) @(posedge pclk);
    rd(B + lpt_pkg::LPT_OFF_STAT, 32'h0000_0002);
    rd(B + lpt_pkg::LPT_OFF_ISR, 32'h0000_0003);
    rd(lpt_pkg::LPT_OFF_CNT, 32'h0000_0000);
    check("irq", 32'(irq), 32'h0000_0000);
    // Mid-run reset, then pin counting with oscillators off; encoder on A only
    tick_on <= 1'b0;
    do_reset;
    wr(lpt_pkg::LPT_OFF_CFG, 32'h0000_0405);
    wr(lpt_pkg::LPT_OFF_CR, 32'h0000_0005);
    wr(B + lpt_pkg::LPT_OFF_CFG, 32'h0000_0405);
    wr(B + lpt_pkg::LPT_OFF_CR, 32'h0000_0005);
    pin_go <= 1'b1;
    repeat (64) @(posedge pclk);
    pin_go <= 1'b0;
    repeat (10) @(posedge pclk);
    rd(lpt_pkg::LPT_OFF_CNT, 32'h0000_0008);
    rd(B + lpt_pkg::LPT_OFF_CNT, 32'h0000_0004);
    wrap_up;
  end
endmodule
`default_nettype wire
